// File: src/arss_defines.svh
// Purpose: timing constants for the rail soft-start sequencer
// Assumes: 100 MHz system clock
// Notes:   one soft-start cycle is 2048 internal oscillator periods
`ifndef ARSS_DEFINES_SVH
`define ARSS_DEFINES_SVH

`define ARSS_CLK_PERIOD_NS     10
`define ARSS_OSC_PERIOD_NS     4000
`define ARSS_OSC_DIV           (`ARSS_OSC_PERIOD_NS / `ARSS_CLK_PERIOD_NS)
`define ARSS_OSC_PER_SS        2048
`define ARSS_SS_CYCLES         (`ARSS_OSC_DIV * `ARSS_OSC_PER_SS)
`define ARSS_RESET_SS_COUNT    3
`define ARSS_PGOOD_SS_COUNT    1
`define ARSS_CNT_W             20
`define ARSS_RAMP_W            8

`endif

// File: src/arss_pkg.sv
// Purpose: types for the rail soft-start sequencer
// Assumes: nothing
// Notes:   state order follows the start sequence
package arss_pkg;

    typedef enum logic [3:0]
    {
        ARSS_OFF,
        ARSS_AMP_RESET,
        ARSS_START_MEM,
        ARSS_START_LOWER,
        ARSS_START_TERM,
        ARSS_START_VTT,
        ARSS_ACTIVE,
        ARSS_SUSPEND
    } arss_state_t;

endpackage

// File: src/arss_sequencer.sv
// Purpose: sleep-state decode and rail start sequencing
// Assumes: rail status and supply reset inputs arrive asynchronously
// Notes:   analog loops, gate drive and fault counter live elsewhere
//
// Behaviour
// R1: start only after both standby and 12V supply resets report good.
// R2: stay off until both sleep requests high and 12V good.
// R3: short error amplifier output to feedback for three soft-start cycles.
// R4: one soft-start cycle is about 8.2ms, the unit for all intervals.
// R5: after amp reset, start memory switcher and upper core together.
// R6: both memory and upper core good, then start lower core.
// R7: core rail good, then start cpu termination regulator.
// R8: cpu termination good, then enable memory termination last.
// R9: switcher reference clamped to a rising digital ramp.
// R10: external linear regulators share a ramp of their own, not the switcher's; memory termination not.
// R11: disabled memory termination shorts reference to output; enable releases.
// R12: one cycle after termination enable, power-good released if cpu good.
// R13: power-good low when cpu termination bad in active, else always low.
// R14: switcher overcurrent trip restarts its soft-start cycle.
// R15: switcher feedback watched for under and overvoltage.
// R16: suspend low with off high keeps only memory rail, power-good low.
// R17: resume reruns three-cycle reset and sequence, memory rail untouched; code waits the three cycles with amp_reset_o held low.
// R18: active to off disables every regulator, power-good low.
// R19: soft-start cycle counts 2048 internal oscillator periods.
// R20: status inputs synchronised; steps advance only on them.
// R21: standby supply reset deassertion returns to off; 12V deassertion too, except in suspend.
`timescale 1ns/1ps
`include "arss_defines.svh"

module arss_sequencer
    import arss_pkg::*;
(
    input  wire logic                    clk_i,
    input  wire logic                    nrst_i,
    input  wire logic                    en_i,
    input  wire logic                    suspend_request_n_i,
    input  wire logic                    soft_off_request_n_i,
    input  wire logic                    standby_por_ok_i,
    input  wire logic                    twelve_por_ok_i,
    input  wire logic                    switcher_good_i,
    input  wire logic                    upper_core_good_i,
    input  wire logic                    core_good_i,
    input  wire logic                    cpu_term_good_i,
    input  wire logic                    switcher_uv_i,
    input  wire logic                    switcher_ov_i,
    input  wire logic                    overcurrent_trip_i,
    output logic                         amp_reset_o,
    output logic                         switcher_en_o,
    output logic                         upper_core_en_o,
    output logic                         lower_core_en_o,
    output logic                         cpu_term_en_o,
    output logic                         mem_term_en_o,
    output logic                         mem_term_ref_short_o,
    output logic [`ARSS_RAMP_W-1:0]      switcher_ramp_o,
    output logic [`ARSS_RAMP_W-1:0]      linear_ramp_o,
    output logic                         switcher_uv_o,
    output logic                         switcher_ov_o,
    output logic                         pgood_oe_o,
    output logic                         pgood_out_o
);

    localparam int NSYNC = 11;

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers

    logic [NSYNC-1:0] raw;
    logic [NSYNC-1:0] sync1;
    logic [NSYNC-1:0] sync2;

    assign raw = {suspend_request_n_i, soft_off_request_n_i,
                  standby_por_ok_i, twelve_por_ok_i, switcher_good_i,
                  upper_core_good_i, core_good_i, cpu_term_good_i,
                  switcher_uv_i, switcher_ov_i, overcurrent_trip_i};

    // R20: two-stage sync
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            sync1 <= '0;
            sync2 <= '0;
        end
        else if (en_i)
        begin
            sync1 <= raw;
            sync2 <= sync1;
        end
    end

    logic s3_n;
    logic s5_n;
    logic sby_ok;
    logic p12_ok;
    logic sw_good;
    logic up_good;
    logic co_good;
    logic ct_good;
    logic sw_uv;
    logic sw_ov;
    logic oc_trip;

    assign {s3_n, s5_n, sby_ok, p12_ok, sw_good, up_good, co_good,
            ct_good, sw_uv, sw_ov, oc_trip} = sync2;

    ////////////////////////////////////////////////////////////////////////
    // soft-start cycle timebase

    // R4 R19: cycle of 2048 periods
    function automatic logic cycle_end(input logic [`ARSS_CNT_W-1:0] c);
        cycle_end = (c == `ARSS_CNT_W'(`ARSS_SS_CYCLES - 1));
    endfunction

    arss_state_t                 state;
    arss_state_t                 next_state;
    logic [`ARSS_CNT_W-1:0]      tick;
    logic [`ARSS_CNT_W-1:0]      next_tick;
    logic [1:0]                  nss;
    logic [1:0]                  next_nss;
    logic                        sw_on;
    logic                        next_sw_on;
    logic [`ARSS_RAMP_W-1:0]     sw_ramp;
    logic [`ARSS_RAMP_W-1:0]     next_sw_ramp;
    logic [`ARSS_RAMP_W-1:0]     lin_ramp;
    logic [`ARSS_RAMP_W-1:0]     next_lin_ramp;
    logic                        pg;
    logic                        next_pg;
    logic                        pg_armed;
    logic                        next_pg_armed;
    logic                        supplies_ok;
    logic                        restart;

    // ramp step once per 2^(cnt_w-ramp_w) clocks, 200 steps per cycle, so full scale takes more than one cycle
    function automatic logic [`ARSS_RAMP_W-1:0] ramp_step(
        input logic [`ARSS_RAMP_W-1:0] r,
        input logic [`ARSS_CNT_W-1:0]  c);
        logic full;
        full = (r == {`ARSS_RAMP_W{1'b1}});
        if (!full && c[11:0] == 12'hfff)
            ramp_step = r + `ARSS_RAMP_W'(1);
        else
            ramp_step = r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // sequencer next state

    always_comb
    begin
        // R1: both supply resets gate start
        supplies_ok = sby_ok && p12_ok;
        restart = 1'b0;
        next_state = state;
        next_tick = cycle_end(tick) ? '0 : tick + `ARSS_CNT_W'(1);
        next_nss = nss;
        next_sw_on = sw_on;
        next_sw_ramp = sw_ramp;
        next_lin_ramp = ramp_step(lin_ramp, tick);
        next_pg = 1'b0;
        next_pg_armed = pg_armed;
        case (state)
            ARSS_OFF:
            begin
                next_sw_on = 1'b0;
                next_sw_ramp = '0;
                next_lin_ramp = '0;
                next_pg_armed = 1'b0;
                // R2: wait for both requests and 12V
                if (supplies_ok && s3_n && s5_n)
                    restart = 1'b1;
            end
            ARSS_AMP_RESET:
            begin
                next_lin_ramp = '0;
                // R3: three soft-start cycles of amp reset
                if (cycle_end(tick))
                begin
                    next_nss = nss + 2'(1);
                    if (nss == 2'(`ARSS_RESET_SS_COUNT - 1))
                    begin
                        // R5: switcher and upper core together
                        next_state = ARSS_START_MEM;
                        next_sw_on = 1'b1;
                    end
                end
            end
            // R6: lower core after both good
            ARSS_START_MEM:
                if (sw_good && up_good)
                begin
                    next_state = ARSS_START_LOWER;
                    next_lin_ramp = '0;
                end
            // R7: cpu termination after core good
            ARSS_START_LOWER:
                if (co_good)
                begin
                    next_state = ARSS_START_TERM;
                    next_lin_ramp = '0;
                end
            ARSS_START_TERM:
                // R8: memory termination last
                if (ct_good)
                begin
                    next_state = ARSS_START_VTT;
                    next_tick = '0;
                end
            ARSS_START_VTT:
                // R12: comparator armed one cycle later
                if (cycle_end(tick))
                begin
                    next_state = ARSS_ACTIVE;
                    next_pg_armed = 1'b1;
                end
            ARSS_ACTIVE:
                // R13: follows cpu termination status
                next_pg = ct_good;
            ARSS_SUSPEND:
            begin
                next_lin_ramp = '0;
                next_pg_armed = 1'b0;
                // R17: resume keeps the memory rail running
                if (s3_n && p12_ok)
                    restart = 1'b1;
            end
            default:
                next_state = ARSS_OFF;
        endcase
        if (restart)
        begin
            next_state = ARSS_AMP_RESET;
            next_tick = '0;
            next_nss = '0;
        end
        // R9: switcher ramp runs while enabled
        if (sw_on)
            next_sw_ramp = ramp_step(sw_ramp, tick);
        // R14: overcurrent restarts switcher ramp
        if (sw_on && oc_trip)
            next_sw_ramp = '0;
        // R16: suspend keeps only the memory rail
        if (state != ARSS_OFF && state != ARSS_SUSPEND && !s3_n && s5_n
            && supplies_ok)
        begin
            next_state = sw_on ? ARSS_SUSPEND : ARSS_OFF;
            next_pg = 1'b0;
            next_pg_armed = 1'b0;
        end
        // R18 R21: off request or supply loss
        if (!s5_n || !sby_ok || (!p12_ok && state != ARSS_SUSPEND))
        begin
            next_state = ARSS_OFF;
            next_sw_on = 1'b0;
            next_sw_ramp = '0;
            next_pg = 1'b0;
            next_pg_armed = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state    <= ARSS_OFF;
            tick     <= '0;
            nss      <= '0;
            sw_on    <= 1'b0;
            sw_ramp  <= '0;
            lin_ramp <= '0;
            pg       <= 1'b0;
            pg_armed <= 1'b0;
        end
        else if (en_i)
        begin
            state    <= next_state;
            tick     <= next_tick;
            nss      <= next_nss;
            sw_on    <= next_sw_on;
            sw_ramp  <= next_sw_ramp;
            lin_ramp <= next_lin_ramp;
            pg       <= next_pg && pg_armed;
            pg_armed <= next_pg_armed;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registered outputs

    logic in_seq;
    assign in_seq = (state == ARSS_START_LOWER || state == ARSS_START_TERM
                     || state == ARSS_START_VTT || state == ARSS_ACTIVE);

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            amp_reset_o          <= 1'b0;
            switcher_en_o        <= 1'b0;
            upper_core_en_o      <= 1'b0;
            lower_core_en_o      <= 1'b0;
            cpu_term_en_o        <= 1'b0;
            mem_term_en_o        <= 1'b0;
            mem_term_ref_short_o <= 1'b1;
            switcher_ramp_o      <= '0;
            linear_ramp_o        <= '0;
            switcher_uv_o        <= 1'b0;
            switcher_ov_o        <= 1'b0;
            pgood_oe_o           <= 1'b1;
            pgood_out_o          <= 1'b0;
        end
        else if (en_i)
        begin
            // R3: amp held only while memory rail not yet running
            amp_reset_o     <= (state == ARSS_AMP_RESET) && !sw_on;
            switcher_en_o   <= sw_on;
            upper_core_en_o <= (state == ARSS_START_MEM) || in_seq;
            lower_core_en_o <= in_seq;
            cpu_term_en_o   <= (state == ARSS_START_TERM)
                               || (state == ARSS_START_VTT)
                               || (state == ARSS_ACTIVE);
            // R11: reference short released on enable
            mem_term_en_o        <= (state == ARSS_START_VTT)
                                    || (state == ARSS_ACTIVE);
            mem_term_ref_short_o <= !((state == ARSS_START_VTT)
                                      || (state == ARSS_ACTIVE));
            switcher_ramp_o <= sw_ramp;
            // R10: shared ramp for external linears
            linear_ramp_o   <= lin_ramp;
            // R15: feedback fault flags
            switcher_uv_o   <= sw_on && sw_uv;
            switcher_ov_o   <= sw_on && sw_ov;
            // R13: open drain, low unless released
            pgood_oe_o      <= !pg;
            pgood_out_o     <= 1'b0;
        end
    end

endmodule

// File: sim/arss_seq_monitor.sv
// Purpose: port checker for the rail start sequencer
// Assumes: en_i mostly high; inputs pass two sync flops
// Notes:   causes lead their effects by three to four clocks
`timescale 1ns/1ps
`include "arss_defines.svh"

module arss_seq_monitor
(
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic       en_i,
    input  wire logic       suspend_request_n_i,
    input  wire logic       soft_off_request_n_i,
    input  wire logic       standby_por_ok_i,
    input  wire logic       twelve_por_ok_i,
    input  wire logic       cpu_term_good_i,
    input  wire logic       switcher_uv_i,
    input  wire logic       overcurrent_trip_i,
    input  wire logic       amp_reset_o,
    input  wire logic       switcher_en_o,
    input  wire logic       upper_core_en_o,
    input  wire logic       lower_core_en_o,
    input  wire logic       cpu_term_en_o,
    input  wire logic       mem_term_en_o,
    input  wire logic       mem_term_ref_short_o,
    input  wire logic [7:0] switcher_ramp_o,
    input  wire logic       switcher_uv_o,
    input  wire logic       pgood_oe_o,
    input  wire logic       pgood_out_o
);
    localparam int AMP_CYC = 3 * `ARSS_SS_CYCLES;
    logic [21:0] amp_cnt;
    logic [21:0] next_amp_cnt;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    ////////////////////////////////////////
    // frozen clocks must not count toward the reset hold
    always_comb
    begin
        next_amp_cnt = amp_reset_o ? amp_cnt + 22'(en_i) : 22'h0;
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            amp_cnt <= 22'h0;
        else
            amp_cnt <= next_amp_cnt;
    end

    ////////////////////////////////////////
    start_gate_a: assert property (
        $rose(amp_reset_o) && !switcher_en_o |->
        $past(standby_por_ok_i, 4) && $past(twelve_por_ok_i, 4) &&
        $past(soft_off_request_n_i, 4) && $past(suspend_request_n_i, 4))
        else $error("start without conditions");
    amp_len_a: assert property (
        $fell(amp_reset_o) && switcher_en_o |-> amp_cnt == AMP_CYC)
        else $error("amp reset length wrong");
    pair_start_a: assert property (
        $rose(upper_core_en_o) |-> switcher_en_o && !amp_reset_o)
        else $error("upper core started alone");
    lower_order_a: assert property (
        lower_core_en_o |-> switcher_en_o && upper_core_en_o)
        else $error("lower core out of order");
    cpu_order_a: assert property (
        cpu_term_en_o |-> lower_core_en_o)
        else $error("cpu term out of order");
    vtt_last_a: assert property (
        (mem_term_en_o != mem_term_ref_short_o) &&
        (!mem_term_en_o || cpu_term_en_o))
        else $error("mem term enable or short wrong");
    pgood_gate_a: assert property (
        !pgood_oe_o |-> mem_term_en_o && !pgood_out_o)
        else $error("power good released early");
    pgood_low_a: assert property (
        (en_i && !cpu_term_good_i)[*6] |-> pgood_oe_o)
        else $error("power good not driven low");
    supply_loss_a: assert property (
        (en_i && !standby_por_ok_i)[*6] |->
        !switcher_en_o && !amp_reset_o && pgood_oe_o)
        else $error("supply loss kept rails on");
    soft_off_a: assert property (
        (en_i && !soft_off_request_n_i)[*6] |->
        !switcher_en_o && !upper_core_en_o && pgood_oe_o)
        else $error("soft off kept rails on");
    suspend_a: assert property (
        (en_i && !suspend_request_n_i)[*6] |->
        !upper_core_en_o && !mem_term_en_o && pgood_oe_o)
        else $error("suspend kept rails on");
    uv_sense_a: assert property (
        (en_i && switcher_en_o && switcher_uv_i)[*4] |-> switcher_uv_o)
        else $error("undervoltage not reported");
    trip_ramp_a: assert property (
        (en_i && overcurrent_trip_i)[*5] |-> switcher_ramp_o == 8'h00)
        else $error("ramp not restarted on trip");
endmodule

bind arss_sequencer arss_seq_monitor i_mon
(
    .clk_i, .nrst_i, .en_i, .suspend_request_n_i, .soft_off_request_n_i,
    .standby_por_ok_i, .twelve_por_ok_i, .cpu_term_good_i, .switcher_uv_i,
    .overcurrent_trip_i, .amp_reset_o, .switcher_en_o, .upper_core_en_o,
    .lower_core_en_o, .cpu_term_en_o, .mem_term_en_o, .mem_term_ref_short_o,
    .switcher_ramp_o, .switcher_uv_o, .pgood_oe_o, .pgood_out_o
);

// File: sim/arss_chipset_model.sv
// Purpose: chipset model driving the two sleep request lines
// Assumes: state code 0 active, 1 suspend, 2 soft-off
// Notes:   lines move only just after a clock edge
`timescale 1ns/1ps

module arss_chipset_model
(
    input  wire logic       clk_i,
    input  wire logic [1:0] state_i,
    output logic            suspend_request_n_o,
    output logic            soft_off_request_n_o
);
    // soft-off pulls suspend low too, as a real chipset does
    always @(posedge clk_i)
    begin
        suspend_request_n_o <= (state_i == 2'h0);
        soft_off_request_n_o <= (state_i != 2'h2);
    end
endmodule

// File: sim/testbench.sv
// Purpose: self-checking bench for the rail start sequencer
// Assumes: 100 MHz clock, reset active low
// Notes:   a full sequence takes millions of clocks, so the run
//          covers the start gate, amp reset entry and its aborts
`timescale 1ns/1ps

module testbench;
    logic       clk_i;
    logic       nrst_i;
    logic       en_i;
    logic [1:0] sleep_cmd;
    logic       standby;
    logic       twelve;
    logic [6:0] rails;
    logic [7:0] prev;
    logic [7:0] exp_q[$];
    wire  logic susp_n;
    wire  logic off_n;
    wire  logic [7:0] outs;
    wire  logic [7:0] sw_ramp;
    wire  logic [7:0] lin_ramp;
    wire  logic [2:0] misc;
    int         errors;
    int         comparisons;
    int         k;

    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    arss_chipset_model i_chipset
    (
        .clk_i, .state_i(sleep_cmd), .suspend_request_n_o(susp_n),
        .soft_off_request_n_o(off_n)
    );

    arss_sequencer i_dut
    (
        .clk_i, .nrst_i, .en_i,
        .suspend_request_n_i(susp_n), .soft_off_request_n_i(off_n),
        .standby_por_ok_i(standby), .twelve_por_ok_i(twelve),
        .switcher_good_i(rails[0]), .upper_core_good_i(rails[1]),
        .core_good_i(rails[2]), .cpu_term_good_i(rails[3]),
        .switcher_uv_i(rails[4]), .switcher_ov_i(rails[5]),
        .overcurrent_trip_i(rails[6]), .amp_reset_o(outs[7]),
        .switcher_en_o(outs[6]), .upper_core_en_o(outs[5]),
        .lower_core_en_o(outs[4]), .cpu_term_en_o(outs[3]),
        .mem_term_en_o(outs[2]), .mem_term_ref_short_o(outs[1]),
        .pgood_oe_o(outs[0]), .switcher_ramp_o(sw_ramp),
        .linear_ramp_o(lin_ramp), .switcher_uv_o(misc[2]),
        .switcher_ov_o(misc[1]), .pgood_out_o(misc[0])
    );

    ////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        comparisons++;
        if (seen !== want)
        begin
            errors++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task automatic tally_and_finish();
        if (errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // drain noted changes, then soak so an early exit would show
    task automatic settle();
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 40)
        begin
            @(posedge clk_i);
            n++;
        end
        if (exp_q.size() != 0)
        begin
            errors++;
            tally_and_finish();
        end
        repeat (12) @(posedge clk_i);
    endtask

    // want[8] set means a change of outs to want[7:0] is due
    task automatic step(input logic [1:0] st, input logic sb,
                        input logic tw, input logic [8:0] want);
        // supplies fall with the command but rise a clock later, so the
        // chipset's one-clock lag never opens a false start window
        @(posedge clk_i);
        sleep_cmd <= st;
        standby <= standby && sb;
        twelve <= twelve && tw;
        rails <= 7'($urandom);
        @(posedge clk_i);
        standby <= sb;
        twelve <= tw;
        if (want[8])
            exp_q.push_back(want[7:0]);
        settle();
    endtask

    ////////////////////////////////////////
    always @(posedge clk_i)
    begin
        if (nrst_i && outs !== prev)
        begin
            if (exp_q.size() == 0)
                check(outs, prev);
            else
                check(outs, exp_q.pop_front());
        end
        prev <= outs;
    end

    initial
    begin
        nrst_i = 1'b0;
        en_i = 1'b1;
        sleep_cmd = 2'h2;
        standby = 1'b0;
        twelve = 1'b0;
        rails = 7'h00;
        prev = 8'h03;
        errors = 0;
        comparisons = 0;
        k = $urandom(51);
        repeat (20) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        check(outs, 8'h03);
        check(sw_ramp | lin_ramp, 8'h00);
        repeat (16)
        begin
            k = $urandom % 4;
            step((k == 0) ? 2'h1 : (k == 1) ? 2'h2 : 2'h0,
                 k != 2, k != 3, 9'h000);
        end
        en_i <= 1'b0;
        step(2'h0, 1'b1, 1'b1, 9'h000);
        en_i <= 1'b1;
        exp_q.push_back(8'h83);
        settle();
        check({5'h00, misc}, 8'h00);
        step(2'h0, 1'b0, 1'b1, 9'h103);
        step(2'h0, 1'b1, 1'b1, 9'h183);
        step(2'h0, 1'b1, 1'b0, 9'h103);
        step(2'h0, 1'b1, 1'b1, 9'h183);
        step(2'h2, 1'b1, 1'b1, 9'h103);
        step(2'h0, 1'b1, 1'b1, 9'h183);
        step(2'h1, 1'b1, 1'b1, 9'h103);
        step(2'h2, 1'b1, 1'b1, 9'h000);
        tally_and_finish();
    end
endmodule
